// ===== dv/fcs_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_regs_tb_top;
  import fcs_pkg::*;
  logic        mclk_i;
  logic        srst_i;
  fcs_bus_s    bus;
  logic [15:0] rdata;
  logic        sample;
  logic [15:0] ph_a;
  logic [15:0] ph_b;
  logic [15:0] ph_c;
  logic        adc_v;
  logic [3:0]  adc_ch;
  logic [15:0] adc_d;
  logic [15:0] alpha;
  logic [15:0] beta;
  logic [15:0] d_volt;
  logic [15:0] q_volt;
  logic [15:0] q_lim;
  logic [7:0]  tmin_lo;
  logic [15:0] speed;
  logic        pwm;
  logic        eng_sel;
  logic        oe_ctl;
  fcs_loop_s   loop;
  fcs_mode_s   mode;
  fcs_timer_s  tmr;
  logic [15:0] coef1;
  logic [15:0] coef2;
  logic [15:0] coef4;
  logic [7:0]  dfc;
  logic [7:0]  qfc;
  int          n_mismatch;
  int          tests_run;

  fcs_regs dut (.mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .sample_i(sample), .phase_a_i(ph_a), .phase_b_i(ph_b), .phase_c_i(ph_c),
    .adc_valid_i(adc_v), .adc_channel_i(adc_ch), .adc_data_i(adc_d),
    .alpha_backemf_i(alpha), .beta_backemf_i(beta), .d_axis_voltage_i(d_volt),
    .q_axis_voltage_i(q_volt), .q_axis_voltage_limit_i(q_lim),
    .min_time_low_i(tmin_lo), .filtered_speed_i(speed), .pwm_cycle_i(pwm),
    .engine_select_i(eng_sel), .output_enable_control_i(oe_ctl),
    .loop_o(loop), .mode_o(mode), .timer_o(tmr), .coef_one_o(coef1),
    .coef_two_o(coef2), .coef_four_o(coef4), .d_filt_coef_o(dfc),
    .q_filt_coef_o(qfc));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // reset values, then all-ones write to see writable bits
  task automatic t_reg_table();
    logic [15:0] a [22] = '{16'h408A, 16'h408C, 16'h408E, 16'h4090, 16'h4092,
      16'h4094, 16'h4096, 16'h4098, 16'h409C, 16'h409E, 16'h40DA, 16'h40DC,
      16'h40DE, 16'h40E0, 16'h40E2, 16'h40E4, 16'h40E6, 16'h40E8, 16'h40E9,
      16'h40EA, 16'h40EE, 16'h4000};
    logic [15:0] rv [22] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
      16'h00FF, 16'h00FF, 0, 0, 0};
    logic [15:0] wv [22] = '{16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFFF, 16'hFFFF,
      16'h7FFF, 16'h7FFF, 0, 16'h7FFF, 16'h7FFF, 0, 0, 0, 0, 16'hFFFF,
      16'hFFFF, 0, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h003F, 0};
    chk({8'h00, dfc}, 16'h00FF);
    chk({8'h00, qfc}, 16'h00FF);
    for (int i = 0; i < 22; i++) rchk(a[i], rv[i]);
    for (int i = 0; i < 22; i++) wr(a[i], 16'hFFFF);
    for (int i = 0; i < 22; i++) rchk(a[i], wv[i]);
    chk(coef1, 16'h7FFF);
    chk(coef2, 16'h7FFF);
    chk(coef4, 16'hFFFF);
  endtask

  // ctrl mode bits and minimum-time extension
  task automatic t_mode();
    tmin_lo <= 8'h5A;
    wr(ADDR_CTRL_THREE, 16'h0037);
    settle(3);
    chk({mode.observer_on, mode.off_sample_on, mode.arctan_on}, 3'b111);
    chk(mode.min_time, 10'h35A);
    wr(ADDR_CTRL_THREE, 16'h0000);
    settle(3);
    chk({mode.observer_on, mode.off_sample_on, mode.arctan_on}, 3'b000);
    chk(mode.min_time, 10'h05A);
    eng_sel <= 1'b1;
    settle(6);
    chk(mode.calc_run, 1'b0);
    wr(ADDR_CTRL_THREE, 16'h0008);
    settle(6);
    chk(mode.calc_run, 1'b1);
    eng_sel <= 1'b0;
    settle(6);
    chk(mode.calc_run, 1'b0);
    oe_ctl <= 1'b1;
    settle(6);
    chk(mode.calc_run, 1'b1);
    oe_ctl <= 1'b0;
  endtask

  task automatic pulse_sample(input logic [15:0] a, b, c);
    @(posedge mclk_i);
    {sample, ph_a, ph_b, ph_c} <= {1'b1, a, b, c};
    @(posedge mclk_i);
    sample <= 1'b0;
  endtask

  // peaks hold the largest value and clear only on request
  task automatic t_peak();
    pulse_sample(16'h1234, 16'h0100, 16'h7000);
    pulse_sample(16'h0100, 16'h2000, 16'hF000);
    settle(4);
    rchk(ADDR_PEAK_A, 16'h1234);
    rchk(ADDR_PEAK_B, 16'h2000);
    rchk(ADDR_PEAK_C, 16'h7000);
    wr(ADDR_CTRL_THREE, 16'h0080);
    settle(3);
    rchk(ADDR_CTRL_THREE, 16'h0000);
    rchk(ADDR_PEAK_A, 16'h0000);
    rchk(ADDR_PEAK_B, 16'h0000);
    rchk(ADDR_PEAK_C, 16'h0000);
  endtask

  // gain selection, setpoints and compensated outputs
  task automatic t_loop();
    wr(ADDR_D_KP, 16'h0000);
    wr(ADDR_SHARED_KP, 16'h0123);
    wr(ADDR_SHARED_KI, 16'h0456);
    wr(ADDR_D_KI, 16'h0654);
    settle(3);
    chk(loop.d_kp, 16'h0123);
    chk(loop.d_ki, 16'h0456);
    wr(ADDR_D_KP, 16'h0321);
    settle(3);
    chk(loop.d_kp, 16'h0321);
    chk(loop.d_ki, 16'h0654);
    wr(ADDR_D_CUR_REF, 16'h8001);
    wr(ADDR_Q_CUR_REF, 16'h7FFF);
    wr(ADDR_D_VCOMP, 16'h0234);
    wr(ADDR_Q_VCOMP, 16'hFFFF);
    wr(ADDR_D_FILT_COEF, 16'h0012);
    wr(ADDR_Q_FILT_COEF, 16'h0034);
    {d_volt, q_volt, q_lim} <= {16'h1000, 16'h2000, 16'h1800};
    settle(3);
    chk(loop.d_ref, 16'h8001);
    chk(loop.q_ref, 16'h7FFF);
    chk({8'h00, dfc}, 16'h0012);
    chk({8'h00, qfc}, 16'h0034);
    chk(loop.d_volt_out, 16'h1234);
    chk(loop.q_volt_out, 16'h1FFF);
    rchk(ADDR_Q_OVERFLOW, 16'h0800);
    q_lim <= 16'h2800;
    settle(3);
    rchk(ADDR_Q_OVERFLOW, 16'hF800);
  endtask

  task automatic pwm_load(output logic seen);
    @(posedge mclk_i);
    pwm <= 1'b1;
    @(posedge mclk_i);
    pwm <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      #1 seen = (tmr.load === 1'b1);
      if (!seen) @(posedge mclk_i);
    end
  endtask

  // frequency-generator period into the companion timer
  task automatic t_fg();
    logic seen;
    speed <= 16'h1234;
    wr(ADDR_FG_COEF, 16'h0000);
    pwm_load(seen);
    chk(seen, 1'b0);
    wr(ADDR_FG_COEF, 16'h8000);
    pwm_load(seen);
    chk(seen, 1'b1);
    chk(tmr.reload, 16'h091A);
    chk(tmr.data, 16'h048D);
    speed <= 16'hFFFF;
    wr(ADDR_FG_COEF, 16'hFFFF);
    pwm_load(seen);
    chk(tmr.reload, 16'hFFFE);
    chk(tmr.overflow, 1'b1);
  endtask

  // back-EMF magnitude and bus-voltage channel selection
  task automatic t_status();
    logic [15:0] d;
    {alpha, beta} <= {16'h0800, 16'h0800};
    settle(60);
    rchk(ADDR_BEMF_MAG, 16'h0B50);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      {adc_v, adc_ch, adc_d} <= {1'b1, k < 4 ? 4'h3 : BUS_VOLT_CHANNEL, 16'h8000};
      @(posedge mclk_i);
      adc_v <= 1'b0;
      if (k == 3) rchk(ADDR_BUS_VOLT, 16'h0000);
    end
    settle(3);
    rd(ADDR_BUS_VOLT, d);
    chk({15'h0000, d[15]}, 16'h0000);
    chk({15'h0000, d != 16'h0000}, 16'h0001);
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    srst_i = 1'b1;
    bus = '0;
    {sample, ph_a, ph_b, ph_c, adc_v, adc_ch, adc_d} = '0;
    {alpha, beta, d_volt, q_volt, q_lim, tmin_lo, speed} = '0;
    {pwm, eng_sel, oe_ctl} = '0;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reg_table();
    t_mode();
    t_peak();
    t_loop();
    t_fg();
    t_status();
    summarize();
  end
endmodule
`default_nettype wire

// ===== inc/fcs_pkg.sv
package fcs_pkg;

  // register byte addresses on the special-function space
  localparam logic [15:0] ADDR_COEF_FOUR   = 16'h408A;
  localparam logic [15:0] ADDR_COEF_ONE    = 16'h408C;
  localparam logic [15:0] ADDR_COEF_TWO    = 16'h408E;
  localparam logic [15:0] ADDR_D_CUR_REF   = 16'h4090;
  localparam logic [15:0] ADDR_Q_CUR_REF   = 16'h4092;
  localparam logic [15:0] ADDR_SHARED_KP   = 16'h4094;
  localparam logic [15:0] ADDR_SHARED_KI   = 16'h4096;
  localparam logic [15:0] ADDR_BUS_VOLT    = 16'h4098;
  localparam logic [15:0] ADDR_D_KP        = 16'h409C;
  localparam logic [15:0] ADDR_D_KI        = 16'h409E;
  localparam logic [15:0] ADDR_PEAK_A      = 16'h40DA;
  localparam logic [15:0] ADDR_PEAK_B      = 16'h40DC;
  localparam logic [15:0] ADDR_PEAK_C      = 16'h40DE;
  localparam logic [15:0] ADDR_BEMF_MAG    = 16'h40E0;
  localparam logic [15:0] ADDR_D_VCOMP     = 16'h40E2;
  localparam logic [15:0] ADDR_Q_VCOMP     = 16'h40E4;
  localparam logic [15:0] ADDR_Q_OVERFLOW  = 16'h40E6;
  localparam logic [15:0] ADDR_D_FILT_COEF = 16'h40E8;
  localparam logic [15:0] ADDR_Q_FILT_COEF = 16'h40E9;
  localparam logic [15:0] ADDR_FG_COEF     = 16'h40EA;
  localparam logic [15:0] ADDR_CTRL_THREE  = 16'h40EE;

  // control byte fields and the read-only gain bit
  localparam int CTL_PEAK_CLEAR_BIT   = 7;
  localparam int CTL_OBSERVER_BIT     = 5;
  localparam int CTL_OFF_SAMPLE_BIT   = 4;
  localparam int CTL_FORCE_CALC_BIT   = 3;
  localparam int CTL_ARCTAN_BIT       = 2;
  localparam int GAIN_RO_BIT          = 15;
  localparam logic [7:0] CTL_WR_MASK  = 8'hBF;

  // reset values
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_FILT    = 8'hFF;
  localparam logic [7:0]  RST_FILT_ZERO = 8'h00;

  // fixed-point formats
  localparam int PROP_FRAC_BITS = 12;
  localparam int INT_FRAC_BITS  = 15;
  // default converter channel for the bus voltage
  localparam logic [3:0] BUS_VOLT_CHANNEL = 4'h2;
  // bus-voltage low-pass shift
  localparam int BUS_FILT_SHIFT = 4;
  localparam int SQRT_STEPS = 16;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } fcs_bus_s;

  typedef struct packed {
    logic [15:0] d_kp;
    logic [15:0] d_ki;
    logic [15:0] d_ref;
    logic [15:0] q_ref;
    logic [15:0] d_volt_out;
    logic [15:0] q_volt_out;
  } fcs_loop_s;

  typedef struct packed {
    logic        observer_on;
    logic        off_sample_on;
    logic        arctan_on;
    logic        calc_run;
    logic [9:0]  min_time;
  } fcs_mode_s;

  typedef struct packed {
    logic [15:0] reload;
    logic [15:0] data;
    logic        load;
    logic        overflow;
  } fcs_timer_s;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_RUN,
    SQ_DONE
  } fcs_sqrt_e;

endpackage

// ===== logic/fcs_regs.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fcs_regs
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  // register port
  input  wire fcs_pkg::fcs_bus_s bus_i,
  output logic [15:0]           rdata_o,
  // engine measurements, same clock
  input  wire logic             sample_i,
  input  wire logic [15:0]      phase_a_i,
  input  wire logic [15:0]      phase_b_i,
  input  wire logic [15:0]      phase_c_i,
  input  wire logic             adc_valid_i,
  input  wire logic [3:0]       adc_channel_i,
  input  wire logic [15:0]      adc_data_i,
  input  wire logic [15:0]      alpha_backemf_i,
  input  wire logic [15:0]      beta_backemf_i,
  input  wire logic [15:0]      d_axis_voltage_i,
  input  wire logic [15:0]      q_axis_voltage_i,
  input  wire logic [15:0]      q_axis_voltage_limit_i,
  input  wire logic [7:0]       min_time_low_i,
  input  wire logic [15:0]      filtered_speed_i,
  input  wire logic             pwm_cycle_i,
  // pins from another domain
  input  wire logic             engine_select_i,
  input  wire logic             output_enable_control_i,
  // engine controls
  output fcs_pkg::fcs_loop_s    loop_o,
  output fcs_pkg::fcs_mode_s    mode_o,
  output fcs_pkg::fcs_timer_s   timer_o,
  output logic [15:0]           coef_one_o,
  output logic [15:0]           coef_two_o,
  output logic [15:0]           coef_four_o,
  output logic [7:0]            d_filt_coef_o,
  output logic [7:0]            q_filt_coef_o
);
  import fcs_pkg::*;

  typedef struct packed {
    logic [15:0] coef1;
    logic [15:0] coef2;
    logic [15:0] coef4;
    logic [15:0] d_ref;
    logic [15:0] q_ref;
    logic [15:0] sh_kp;
    logic [15:0] sh_ki;
    logic [15:0] d_kp;
    logic [15:0] d_ki;
    logic [15:0] bus_v;
    logic [15:0] pk_a;
    logic [15:0] pk_b;
    logic [15:0] pk_c;
    logic [15:0] bemf;
    logic [15:0] d_comp;
    logic [15:0] q_comp;
    logic [15:0] q_ovf;
    logic [7:0]  d_filt;
    logic [7:0]  q_filt;
    logic [15:0] fg_coef;
    logic [7:0]  ctrl;
    logic [15:0] rdata;
    logic [1:0]  sel_sync1;
    logic [1:0]  sel_sync2;
    fcs_loop_s   loop;
    fcs_mode_s   mode;
    fcs_timer_s  timer;
    logic        sq_start;
  } fcs_state_s;

  fcs_state_s s_reg;
  fcs_state_s s_next;

  logic        sq_done;
  logic [15:0] sq_root;
  logic [31:0] sum_sq;
  logic [31:0] alpha_sq;
  logic [31:0] beta_sq;
  logic [31:0] fg_prod;
  logic [15:0] d_out;
  logic [15:0] q_out;
  logic [16:0] ovf_wide;
  logic [15:0] d_kp_sel;
  logic [15:0] d_ki_sel;

  // magnitudes squared; signed operands give non-negative squares
  assign alpha_sq = 32'($signed(alpha_backemf_i) * $signed(alpha_backemf_i));
  assign beta_sq  = 32'($signed(beta_backemf_i) * $signed(beta_backemf_i));
  assign sum_sq   = alpha_sq + beta_sq;

  fcs_sqrt u_sqrt (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .start_i    (s_reg.sq_start),
    .radicand_i (sum_sq),
    .done_o     (sq_done),
    .root_o     (sq_root)
  );

  // unsigned gain times speed, upper half is the period
  assign fg_prod  = filtered_speed_i * s_reg.fg_coef;
  assign ovf_wide = 17'($signed(q_axis_voltage_i))
                  - 17'($signed(q_axis_voltage_limit_i));
  assign d_out    = d_axis_voltage_i + s_reg.d_comp;
  assign q_out    = q_axis_voltage_i + s_reg.q_comp;
  assign d_kp_sel = (s_reg.d_kp != RST_WORD) ? s_reg.d_kp : s_reg.sh_kp;
  assign d_ki_sel = (s_reg.d_kp != RST_WORD) ? s_reg.d_ki : s_reg.sh_ki;

  always_comb begin
    s_next = s_reg;
    s_next.sq_start = 1'b0;
    s_next.timer.load = 1'b0;

    // two flops on the pins; only the second stage is read
    s_next.sel_sync1 = {engine_select_i, output_enable_control_i};
    s_next.sel_sync2 = s_reg.sel_sync1;

    // register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_COEF_FOUR:   s_next.coef4 = bus_i.wdata;
        ADDR_COEF_ONE:    s_next.coef1 = {1'b0, bus_i.wdata[14:0]};
        ADDR_COEF_TWO:    s_next.coef2 = {1'b0, bus_i.wdata[14:0]};
        ADDR_D_CUR_REF:   s_next.d_ref = bus_i.wdata;
        ADDR_Q_CUR_REF:   s_next.q_ref = bus_i.wdata;
        ADDR_SHARED_KP:   s_next.sh_kp = {1'b0, bus_i.wdata[14:0]};
        ADDR_SHARED_KI:   s_next.sh_ki = {1'b0, bus_i.wdata[14:0]};
        ADDR_D_KP:        s_next.d_kp  = {1'b0, bus_i.wdata[14:0]};
        ADDR_D_KI:        s_next.d_ki  = {1'b0, bus_i.wdata[14:0]};
        ADDR_D_VCOMP:     s_next.d_comp = bus_i.wdata;
        ADDR_Q_VCOMP:     s_next.q_comp = bus_i.wdata;
        ADDR_D_FILT_COEF: s_next.d_filt = bus_i.wdata[7:0];
        ADDR_Q_FILT_COEF: s_next.q_filt = bus_i.wdata[7:0];
        ADDR_FG_COEF:     s_next.fg_coef = bus_i.wdata;
        ADDR_CTRL_THREE:  s_next.ctrl = bus_i.wdata[7:0] & CTL_WR_MASK;
        default: ;
      endcase
    end

    // peak tracking; clear has one cycle, then the bit drops
    if (s_reg.ctrl[CTL_PEAK_CLEAR_BIT]) begin
      s_next.pk_a = RST_WORD;
      s_next.pk_b = RST_WORD;
      s_next.pk_c = RST_WORD;
      s_next.ctrl[CTL_PEAK_CLEAR_BIT] = 1'b0;
      if (bus_i.wr && bus_i.addr == ADDR_CTRL_THREE) begin
        s_next.ctrl[CTL_PEAK_CLEAR_BIT] = bus_i.wdata[CTL_PEAK_CLEAR_BIT];
      end
    end else if (sample_i) begin
      if ($signed(phase_a_i) > $signed(s_reg.pk_a)) s_next.pk_a = phase_a_i;
      if ($signed(phase_b_i) > $signed(s_reg.pk_b)) s_next.pk_b = phase_b_i;
      if ($signed(phase_c_i) > $signed(s_reg.pk_c)) s_next.pk_c = phase_c_i;
    end

    // bus voltage filter: first-order, result kept positive
    if (adc_valid_i && adc_channel_i == BUS_VOLT_CHANNEL) begin
      s_next.bus_v = 16'(s_reg.bus_v
        + 16'(($signed({1'b0, adc_data_i[15:1]})
        - $signed({1'b0, s_reg.bus_v[14:0]})) >>> BUS_FILT_SHIFT));
      s_next.bus_v[15] = 1'b0;
    end

    // back-EMF magnitude, restarted once each result lands
    if (sq_done || (s_reg.bemf == RST_WORD && !s_reg.sq_start)) begin
      s_next.sq_start = 1'b1;
    end
    if (sq_done) begin
      // the true root can pass the 15-bit range, so it saturates
      s_next.bemf = sq_root[15] ? 16'h7FFF : sq_root;
    end

    // flux-weakening overflow, saturated to the signed range
    if (ovf_wide[16] != ovf_wide[15]) begin
      s_next.q_ovf = ovf_wide[16] ? 16'h8000 : 16'h7FFF;
    end else begin
      s_next.q_ovf = ovf_wide[15:0];
    end

    // loop outputs
    s_next.loop.d_kp = d_kp_sel;
    s_next.loop.d_ki = d_ki_sel;
    s_next.loop.d_ref = s_reg.d_ref;
    s_next.loop.q_ref = s_reg.q_ref;
    s_next.loop.d_volt_out = d_out;
    s_next.loop.q_volt_out = q_out;

    // mode bits
    s_next.mode.observer_on   = s_reg.ctrl[CTL_OBSERVER_BIT];
    s_next.mode.off_sample_on = s_reg.ctrl[CTL_OFF_SAMPLE_BIT];
    s_next.mode.arctan_on     = s_reg.ctrl[CTL_ARCTAN_BIT];
    s_next.mode.min_time = {s_reg.ctrl[1:0], min_time_low_i};
    s_next.mode.calc_run = s_reg.sel_sync2[0]
      || (s_reg.sel_sync2[1] && s_reg.ctrl[CTL_FORCE_CALC_BIT]);

    // FG period per PWM cycle; top-of-range period asks for a slower divider
    if (pwm_cycle_i && s_reg.fg_coef != RST_WORD) begin
      s_next.timer.reload = fg_prod[31:16];
      s_next.timer.data   = {1'b0, fg_prod[31:17]};
      s_next.timer.load   = 1'b1;
      s_next.timer.overflow = (fg_prod[31:17] == 15'h7FFF);
    end

    // read data one cycle after the strobe
    s_next.rdata = RST_WORD;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_COEF_FOUR:   s_next.rdata = s_reg.coef4;
        ADDR_COEF_ONE:    s_next.rdata = s_reg.coef1;
        ADDR_COEF_TWO:    s_next.rdata = s_reg.coef2;
        ADDR_D_CUR_REF:   s_next.rdata = s_reg.d_ref;
        ADDR_Q_CUR_REF:   s_next.rdata = s_reg.q_ref;
        ADDR_SHARED_KP:   s_next.rdata = s_reg.sh_kp;
        ADDR_SHARED_KI:   s_next.rdata = s_reg.sh_ki;
        ADDR_BUS_VOLT:    s_next.rdata = s_reg.bus_v;
        ADDR_D_KP:        s_next.rdata = s_reg.d_kp;
        ADDR_D_KI:        s_next.rdata = s_reg.d_ki;
        ADDR_PEAK_A:      s_next.rdata = s_reg.pk_a;
        ADDR_PEAK_B:      s_next.rdata = s_reg.pk_b;
        ADDR_PEAK_C:      s_next.rdata = s_reg.pk_c;
        ADDR_BEMF_MAG:    s_next.rdata = s_reg.bemf;
        ADDR_D_VCOMP:     s_next.rdata = s_reg.d_comp;
        ADDR_Q_VCOMP:     s_next.rdata = s_reg.q_comp;
        ADDR_Q_OVERFLOW:  s_next.rdata = s_reg.q_ovf;
        ADDR_D_FILT_COEF: s_next.rdata = {RST_FILT_ZERO, s_reg.d_filt};
        ADDR_Q_FILT_COEF: s_next.rdata = {RST_FILT_ZERO, s_reg.q_filt};
        ADDR_FG_COEF:     s_next.rdata = s_reg.fg_coef;
        ADDR_CTRL_THREE:  s_next.rdata = {RST_FILT_ZERO, s_reg.ctrl};
        default:          s_next.rdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_reg <= '0;
      s_reg.d_filt <= RST_FILT;
      s_reg.q_filt <= RST_FILT;
      s_reg.ctrl <= RST_CTRL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o       = s_reg.rdata;
  assign loop_o        = s_reg.loop;
  assign mode_o        = s_reg.mode;
  assign timer_o       = s_reg.timer;
  assign coef_one_o    = s_reg.coef1;
  assign coef_two_o    = s_reg.coef2;
  assign coef_four_o   = s_reg.coef4;
  assign d_filt_coef_o = s_reg.d_filt;
  assign q_filt_coef_o = s_reg.q_filt;

  // assertions
  default clocking main_cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  // a clear lasts one cycle; the bit written again re-arms it
  sequence clear_armed;
    s_reg.ctrl[CTL_PEAK_CLEAR_BIT] && !bus_i.wr;
  endsequence
  sequence peaks_zeroed;
    s_reg.pk_a == RST_WORD && s_reg.pk_b == RST_WORD
    && s_reg.pk_c == RST_WORD && !s_reg.ctrl[CTL_PEAK_CLEAR_BIT];
  endsequence

  peak_clear_self_a: assert property (
    clear_armed |=> peaks_zeroed)
    else $error("peak clear did not complete");
  peak_hold_a: assert property (
    !s_reg.ctrl[CTL_PEAK_CLEAR_BIT] |=>
    $signed(s_reg.pk_a) >= $signed($past(s_reg.pk_a)))
    else $error("peak value fell without clear");
  observer_bit_a: assert property (
    ##1 mode_o.observer_on == $past(s_reg.ctrl[CTL_OBSERVER_BIT]))
    else $error("observer enable mismatch");
  off_sample_a: assert property (
    ##1 mode_o.off_sample_on == $past(s_reg.ctrl[CTL_OFF_SAMPLE_BIT]))
    else $error("off-interval sampling enable mismatch");
  arctan_bit_a: assert property (
    ##1 mode_o.arctan_on == $past(s_reg.ctrl[CTL_ARCTAN_BIT]))
    else $error("arctangent enable mismatch");
  min_time_a: assert property (
    ##1 mode_o.min_time == {$past(s_reg.ctrl[1:0]), $past(min_time_low_i)})
    else $error("minimum time upper bits mismatch");
  force_calc_a: assert property (
    s_reg.sel_sync2 == 2'b10 && s_reg.ctrl[CTL_FORCE_CALC_BIT]
    |=> mode_o.calc_run)
    else $error("forced calculation not running");
  d_gain_sel_a: assert property (
    s_reg.d_kp == RST_WORD |=> loop_o.d_kp == $past(s_reg.sh_kp))
    else $error("shared gain not used");
  gain_msb_zero_a: assert property (
    !s_reg.sh_kp[GAIN_RO_BIT] && !s_reg.d_ki[GAIN_RO_BIT]
    && !s_reg.sh_ki[GAIN_RO_BIT] && !s_reg.d_kp[GAIN_RO_BIT])
    else $error("read-only gain bit set");
  coef_msb_zero_a: assert property (
    !s_reg.coef1[GAIN_RO_BIT] && !s_reg.coef2[GAIN_RO_BIT])
    else $error("read-only coefficient bit set");
  filt_reset_a: assert property (
    $fell(srst_i) |->
    s_reg.d_filt == RST_FILT && s_reg.q_filt == RST_FILT)
    else $error("filter coefficient not all ones after reset");
  bus_volt_pos_a: assert property (
    !s_reg.bus_v[15])
    else $error("bus voltage left its positive range");
  bemf_update_a: assert property (
    sq_done && !sq_root[15] |=> s_reg.bemf == $past(sq_root))
    else $error("back-EMF magnitude not updated");
  d_comp_sum_a: assert property (
    ##1 loop_o.d_volt_out
      == 16'($past(d_axis_voltage_i) + $past(s_reg.d_comp)))
    else $error("d output not compensated");
  q_comp_sum_a: assert property (
    ##1 loop_o.q_volt_out
      == 16'($past(q_axis_voltage_i) + $past(s_reg.q_comp)))
    else $error("q output not compensated");
  q_ovf_neg_a: assert property (
    $signed(q_axis_voltage_i) < $signed(q_axis_voltage_limit_i)
    |=> s_reg.q_ovf[15])
    else $error("q overflow not negative below limit");
  q_ovf_pos_a: assert property (
    $signed(q_axis_voltage_i) >= $signed(q_axis_voltage_limit_i)
    |=> !s_reg.q_ovf[15])
    else $error("q overflow negative at or above limit");
  ref_pass_a: assert property (
    ##1 loop_o.d_ref == $past(s_reg.d_ref)
    && loop_o.q_ref == $past(s_reg.q_ref))
    else $error("current reference not forwarded");
  fg_disabled_a: assert property (
    s_reg.fg_coef == RST_WORD |=> !timer_o.load)
    else $error("timer loaded with zero coefficient");
  fg_half_a: assert property (
    timer_o.load |-> timer_o.data == (timer_o.reload >> 1))
    else $error("timer data not half of reload");
endmodule
`default_nettype wire

// ===== logic/fcs_sqrt.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_sqrt
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // operand
  input  wire logic        start_i,
  input  wire logic [31:0] radicand_i,
  // result
  output logic             done_o,
  output logic [15:0]      root_o
);
  typedef struct packed {
    fcs_sqrt_e   st;
    logic [31:0] rem;
    logic [31:0] bit_w;
    logic [31:0] res;
    logic        done;
    logic [15:0] root;
  } fcs_sq_state_s;

  fcs_sq_state_s s_reg;
  fcs_sq_state_s s_next;
  logic [31:0]   trial;

  // bit-serial root: one result bit per cycle keeps area small
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    trial = s_reg.res + s_reg.bit_w;
    case (s_reg.st)
      SQ_IDLE: begin
        if (start_i) begin
          s_next.rem   = radicand_i;
          s_next.bit_w = 32'h40000000;
          s_next.res   = 32'h00000000;
          s_next.st    = SQ_RUN;
        end
      end
      SQ_RUN: begin
        if (s_reg.rem >= trial) begin
          s_next.rem = s_reg.rem - trial;
          s_next.res = (s_reg.res >> 1) + s_reg.bit_w;
        end else begin
          s_next.res = s_reg.res >> 1;
        end
        s_next.bit_w = s_reg.bit_w >> 2;
        if (s_reg.bit_w == 32'h00000001) begin
          s_next.st = SQ_DONE;
        end
      end
      SQ_DONE: begin
        s_next.root = s_reg.res[15:0];
        s_next.done = 1'b1;
        s_next.st   = SQ_IDLE;
      end
      default: s_next.st = SQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_o = s_reg.done;
  assign root_o = s_reg.root;
endmodule
`default_nettype wire
